//--- exception_vector_priority.sv
// exception recognition, class priority and vector dispatch with an AXI4-Lite register port
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module exception_vector_priority
	import exc_pkg::*;
#(
	parameter vec_t VEC_SRESET = 16'h0000,
	parameter vec_t VEC_MCHECK = 16'h0000,
	parameter vec_t VEC_EXT    = 16'h0000
)(
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic [3:0]     s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	input  wire logic [3:0]     s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready,
	input  wire logic           sys_reset_req,
	input  wire logic           mcheck_req,
	input  wire logic           dec_event,
	input  wire logic           system_mgmt_interrupt_in_n,
	input  wire logic           ext_interrupt_in_n,
	input  wire logic           complete_valid,
	input  wire logic [31:0]    complete_addr,
	input  precise_flags_t      complete_flags,
	input  wire logic           core_ready,
	input  wire logic           handler_done,
	output logic                exc_take,
	output vec_t                exc_vector,
	output cause_t              exc_cause,
	output logic                in_handler,
	output logic                checkstop
);
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = data[8*i +: 8];
		end
		return r;
	endfunction

	function automatic vec_t vector_of(input cause_t g);
		vec_t v;
		v = 16'h0000;
		if (g[C_SRESET]) v = VEC_SRESET;
		if (g[C_MCHECK]) v = VEC_MCHECK;
		if (g[C_INSTRUCTION_TRANSLATION_BUFFER])   v = VEC_INSTRUCTION_TRANSLATION_BUFFER;
		if (g[C_BKPT])   v = VEC_BKPT;
		if (g[C_LOAD])   v = VEC_LOAD;
		if (g[C_STORE])  v = VEC_STORE;
		if (g[C_SMI])    v = VEC_SMI;
		if (g[C_EXT])    v = VEC_EXT;
		if (g[C_DEC])    v = VEC_DEC;
		return v;
	endfunction

	logic [1:0]  smi_meta;
	logic [1:0]  ext_meta;
	logic [31:0] breakpoint_address_compare;
	logic [1:0]  ctrl;
	logic        sreset_pend;
	logic        mc_pend;
	logic        dec_pend;
	exc_state_t  state;
	exc_state_t  next_state;
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// pin synchronisers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			smi_meta <= 2'h3;
			ext_meta <= 2'h3;
		end
		else
		begin
			smi_meta <= {smi_meta[0], system_mgmt_interrupt_in_n};
			ext_meta <= {ext_meta[0], ext_interrupt_in_n};
		end
	end

	wire external_interrupt_enable = ctrl[CTRL_EE_BIT];
	wire mcheck_enable = ctrl[CTRL_ME_BIT];
	wire smi_active = !smi_meta[1];
	wire ext_active = !ext_meta[1];
	wire bkpt_hit = complete_valid && breakpoint_address_compare[BKPT_EN_BIT]
		&& (complete_addr[31:2] == breakpoint_address_compare[31:2]);
	wire live = (state != ST_CHECKSTOP);
	wire go_checkstop = live && mc_pend && !mcheck_enable && !sreset_pend;
	wire nm_any = live && (sreset_pend || (mc_pend && mcheck_enable));
	wire can_defer = (state == ST_RUN) && core_ready && !nm_any && !go_checkstop;
	wire precise_ok = can_defer && complete_valid;
	wire mask_ok = can_defer && external_interrupt_enable;

	cause_t req;
	assign req[C_SRESET] = live && sreset_pend;
	assign req[C_MCHECK] = live && mc_pend && mcheck_enable;
	assign req[C_INSTRUCTION_TRANSLATION_BUFFER]   = precise_ok && complete_flags.fetch_miss;
	assign req[C_BKPT]   = precise_ok && bkpt_hit;
	assign req[C_LOAD]   = precise_ok && complete_flags.load_miss;
	assign req[C_STORE]  = precise_ok && (complete_flags.store_miss || complete_flags.store_change);
	wire precise_pend = complete_valid && (bkpt_hit || (|complete_flags));
	assign req[C_SMI]    = mask_ok && !precise_pend && smi_active;
	assign req[C_EXT]    = mask_ok && !precise_pend && ext_active;
	assign req[C_DEC]    = mask_ok && !precise_pend && dec_pend;
	wire cause_t grant = req & ~(req - 9'h001);
	wire take_now = |grant;

	always_comb
	begin
		next_state = state;
		if (go_checkstop)
			next_state = ST_CHECKSTOP;
		else if (take_now)
			next_state = ST_HANDLER;
		else if (state == ST_HANDLER && handler_done)
			next_state = ST_RUN;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state       <= ST_RUN;
			sreset_pend <= 1'b0;
			mc_pend     <= 1'b0;
			dec_pend    <= 1'b0;
			exc_take    <= 1'b0;
			exc_vector  <= 16'h0000;
			exc_cause   <= 9'h000;
			in_handler  <= 1'b0;
			checkstop   <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			sreset_pend <= sys_reset_req || (sreset_pend && !grant[C_SRESET]);
			mc_pend     <= mcheck_req || (mc_pend && !grant[C_MCHECK] && !go_checkstop);
			dec_pend    <= dec_event || (dec_pend && !grant[C_DEC]);
			exc_take    <= take_now;
			exc_cause   <= grant;
			in_handler  <= (next_state == ST_HANDLER);
			checkstop   <= (next_state == ST_CHECKSTOP);
			if (take_now)
				exc_vector <= vector_of(grant);
		end
	end

	// register port
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire wr_bkpt = do_write && (aw_addr == OFF_BKPT);
	wire wr_ctrl = do_write && (aw_addr == OFF_CTRL);
	wire wr_mapped = (aw_addr == OFF_BKPT) || (aw_addr == OFF_CTRL) || (aw_addr == OFF_STATUS)
		|| (aw_addr == OFF_LASTVEC);
	wire rd_mapped = (s_axi_araddr == OFF_BKPT) || (s_axi_araddr == OFF_CTRL)
		|| (s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_LASTVEC);
	wire [31:0] status_word = {27'h0, mc_pend, sreset_pend, dec_pend, in_handler, checkstop};
	wire [31:0] ctrl_word = {30'h0, ctrl};
	wire [31:0] rd_word = (s_axi_araddr == OFF_BKPT) ? breakpoint_address_compare :
		(s_axi_araddr == OFF_CTRL) ? ctrl_word :
		(s_axi_araddr == OFF_STATUS) ? status_word :
		(s_axi_araddr == OFF_LASTVEC) ? {7'h0, exc_cause, exc_vector} : 32'h0000_0000;
	wire [31:0] ctrl_new = merge_bytes(ctrl_word, w_data, w_strb);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			breakpoint_address_compare <= BKPT_RESET;
			ctrl                       <= CTRL_RESET;
		end
		else
		begin
			if (wr_bkpt)
				breakpoint_address_compare <= merge_bytes(breakpoint_address_compare, w_data, w_strb);
			if (wr_ctrl)
				ctrl <= ctrl_new[1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_fire)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_instruction_translation_buffer_vector: assert property (req[C_INSTRUCTION_TRANSLATION_BUFFER] |=> exc_take && exc_vector == VEC_INSTRUCTION_TRANSLATION_BUFFER)
		else $error("fetch miss not vectored to its offset");
	chk_load_vector: assert property (precise_ok && complete_flags.load_miss && !complete_flags.fetch_miss
		&& !bkpt_hit |=> exc_vector == VEC_LOAD && exc_cause[C_LOAD])
		else $error("load miss not vectored to its offset");
	chk_store_cause: assert property (exc_take && exc_cause[C_STORE] |-> exc_vector == VEC_STORE
		&& $past(complete_flags.store_miss || complete_flags.store_change))
		else $error("store vector without store fault");
	chk_bkpt_match: assert property (exc_take && exc_cause[C_BKPT] |-> $past(breakpoint_address_compare[BKPT_EN_BIT]
		&& complete_addr[31:2] == breakpoint_address_compare[31:2]) && exc_vector == VEC_BKPT)
		else $error("breakpoint taken without enabled match");
	chk_smi_gate: assert property (exc_take && exc_cause[C_SMI] |-> $past(external_interrupt_enable)
		&& $past(smi_active) && exc_vector == VEC_SMI)
		else $error("smi taken while masked or idle");
	chk_nm_first: assert property (live && sreset_pend |=> exc_take && exc_cause[C_SRESET])
		else $error("system reset not taken first");
	chk_mc_stop: assert property (go_checkstop |=> checkstop [*2])
		else $error("disabled machine check did not stop");
	chk_precise_slot: assert property (exc_take && |(exc_cause & PRECISE_MASK) |-> $past(complete_valid))
		else $error("precise exception without completing instruction");
	chk_mask_hold: assert property (exc_take && |(exc_cause & MASKABLE_MASK) |-> !$past(precise_pend)
		&& !$past(nm_any))
		else $error("maskable taken over higher class");
	chk_nm_nowait: assert property (live && mc_pend && mcheck_enable && !core_ready |=> exc_take)
		else $error("machine check waited for core");
	chk_nm_preempt: assert property (in_handler && sreset_pend |=> exc_take && exc_cause[C_SRESET])
		else $error("system reset blocked by handler");
	chk_defer_busy: assert property (!core_ready && !nm_any |=> !exc_take)
		else $error("deferrable exception taken while busy");
	chk_one_take: assert property (exc_take |-> $onehot(exc_cause))
		else $error("more than one exception taken");
endmodule

//--- exc_pkg.sv
// shared constants and types for the exception dispatch block
package exc_pkg;
	typedef logic [15:0] vec_t;
	typedef logic [8:0]  cause_t;

	// vector offsets
	localparam vec_t VEC_INSTRUCTION_TRANSLATION_BUFFER  = 16'h1000;
	localparam vec_t VEC_LOAD  = 16'h1100;
	localparam vec_t VEC_STORE = 16'h1200;
	localparam vec_t VEC_BKPT  = 16'h1300;
	localparam vec_t VEC_SMI   = 16'h1400;
	localparam vec_t VEC_DEC   = 16'h0900;

	// cause bit positions, highest priority first
	localparam int C_SRESET = 0;
	localparam int C_MCHECK = 1;
	localparam int C_INSTRUCTION_TRANSLATION_BUFFER   = 2;
	localparam int C_BKPT   = 3;
	localparam int C_LOAD   = 4;
	localparam int C_STORE  = 5;
	localparam int C_SMI    = 6;
	localparam int C_EXT    = 7;
	localparam int C_DEC    = 8;
	localparam cause_t NONMASK_MASK  = 9'h003;
	localparam cause_t PRECISE_MASK  = 9'h03C;
	localparam cause_t MASKABLE_MASK = 9'h1C0;

	// register map
	localparam logic [3:0] OFF_BKPT    = 4'h0;
	localparam logic [3:0] OFF_CTRL    = 4'h4;
	localparam logic [3:0] OFF_STATUS  = 4'h8;
	localparam logic [3:0] OFF_LASTVEC = 4'hC;
	localparam int BKPT_EN_BIT = 1;
	localparam int CTRL_EE_BIT = 0;
	localparam int CTRL_ME_BIT = 1;
	localparam logic [31:0] BKPT_RESET = 32'h0000_0000;
	localparam logic [1:0]  CTRL_RESET = 2'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// translation fault flags of the instruction at completion
	typedef struct packed {
		logic fetch_miss;
		logic load_miss;
		logic store_miss;
		logic store_change;
	} precise_flags_t;

	typedef enum logic [2:0] {
		ST_RUN       = 3'h1,
		ST_HANDLER   = 3'h2,
		ST_CHECKSTOP = 3'h4
	} exc_state_t;
endpackage

//--- core_model.sv
// behavioural completion pipeline facing the exception block
`timescale 1ns/1ps
module core_model
	import exc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [31:0] addr,
	input  precise_flags_t   flags,
	input  wire logic        slow,
	input  wire logic        exc_take,
	input  wire logic        in_handler,
	output logic             complete_valid = 1'b0,
	output logic [31:0]      complete_addr = 32'h0,
	output precise_flags_t   complete_flags = '0,
	output logic             core_ready = 1'b1,
	output logic             handler_done = 1'b0
);
	int hold;
	int hcnt;
	always @(posedge clk)
	begin
		handler_done <= 1'b0;
		hcnt <= in_handler ? hcnt + 1 : 0;
		if (in_handler && hcnt == (slow ? 8 : 4))
		begin
			handler_done <= 1'b1;
			hcnt <= 0;
		end
		if (!rst_n)
		begin
			complete_valid <= 1'b0;
			core_ready <= 1'b1;
		end
		else if (go)
		begin
			// one instruction at a time, held until taken or until hold reaches 10
			complete_valid <= 1'b1;
			complete_addr <= addr;
			complete_flags <= flags;
			core_ready <= !slow;
			hold <= 0;
		end
		else if (complete_valid)
		begin
			hold <= hold + 1;
			if (hold >= 3)
				core_ready <= 1'b1;
			if (exc_take || hold == 10)
			begin
				// released lines do not keep the old value
				complete_valid <= 1'b0;
				complete_addr <= ~complete_addr;
				complete_flags <= ~complete_flags;
			end
		end
	end
endmodule

//--- tb.sv
// self-checking bench for the exception dispatch block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); miscompares++; end end
module tb
	import exc_pkg::*;
;
	localparam vec_t        V_SR = 16'h0100;
	localparam vec_t        V_MC = 16'h0200;
	localparam vec_t        V_EXT = 16'h0500;
	localparam logic [31:0] BK_A = 32'h0000_4A5C;
	logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, m_addr, cm_addr, ra;
	logic [1:0] bresp, rresp;
	logic sr_req, mc_req, dec_ev, smi_n, ext_n, cm_valid, core_rdy, h_done, exc_take, in_handler, checkstop;
	logic go, slow;
	precise_flags_t m_flags, cm_flags;
	vec_t exc_vector;
	cause_t exc_cause;
	int miscompares, cmp_count, i, k;
	integer seed;
	vec_t vt [9] = '{V_SR, V_MC, VEC_INSTRUCTION_TRANSLATION_BUFFER, VEC_BKPT, VEC_LOAD, VEC_STORE, VEC_SMI, V_EXT, VEC_DEC};

	exception_vector_priority #(.VEC_SRESET(V_SR), .VEC_MCHECK(V_MC), .VEC_EXT(V_EXT)) dut (.clk(clk),
		.rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sys_reset_req(sr_req), .mcheck_req(mc_req),
		.dec_event(dec_ev), .system_mgmt_interrupt_in_n(smi_n), .ext_interrupt_in_n(ext_n),
		.complete_valid(cm_valid), .complete_addr(cm_addr), .complete_flags(cm_flags), .core_ready(core_rdy),
		.handler_done(h_done), .exc_take(exc_take), .exc_vector(exc_vector), .exc_cause(exc_cause),
		.in_handler(in_handler), .checkstop(checkstop));
	core_model core (.clk(clk), .rst_n(rst_n), .go(go), .addr(m_addr), .flags(m_flags), .slow(slow),
		.exc_take(exc_take), .in_handler(in_handler), .complete_valid(cm_valid), .complete_addr(cm_addr),
		.complete_flags(cm_flags), .core_ready(core_rdy), .handler_done(h_done));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic test_done();
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic fail_to();
		miscompares++;
		test_done();
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 50 && !b; n++)
		begin
			@(negedge clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b)
			fail_to();
		`CHK("bresp", er, r)
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, v;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		for (n = 0; n < 50 && !v; n++)
		begin
			@(negedge clk);
			ar = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!v)
			fail_to();
		`CHK("rdata", ed, d)
		`CHK("rresp", er, r)
	endtask

	task automatic take_chk(input int c);
		int n;
		for (n = 0; n < 40; n++)
		begin
			@(negedge clk);
			if (exc_take === 1'b1)
				break;
		end
		if (n == 40)
			fail_to();
		`CHK("cause", cause_t'(1) << c, exc_cause)
		`CHK("vector", vt[c], exc_vector)
		@(posedge clk);
	endtask

	task automatic no_take(input int c);
		repeat (c)
		begin
			@(negedge clk);
			`CHK("take", 1'b0, exc_take)
		end
		@(posedge clk);
	endtask

	task automatic idle();
		int n;
		for (n = 0; n < 40; n++)
		begin
			@(negedge clk);
			if (in_handler === 1'b0 && cm_valid === 1'b0)
				break;
		end
		if (n == 40)
			fail_to();
		@(posedge clk);
	endtask

	task automatic issue(input logic [31:0] a, input logic [3:0] f, input logic s);
		m_addr <= a;
		m_flags <= f;
		slow <= s;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask

	function automatic int exp_idx(input logic [3:0] f, input logic bk);
		if (f[3])
			return C_INSTRUCTION_TRANSLATION_BUFFER;
		if (bk)
			return C_BKPT;
		if (f[2])
			return C_LOAD;
		if (f[1] || f[0])
			return C_STORE;
		return -1;
	endfunction

	initial
	begin
		seed = 32'hD3C5E7D0;
		{awvalid, wvalid, bready, arvalid, rready, sr_req, mc_req, dec_ev, go, slow} = '0;
		{awaddr, araddr, wdata, m_addr, m_flags} = '0;
		wstrb = 4'hF;
		{smi_n, ext_n} = 2'h3;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(OFF_BKPT, 32'h0, RESP_OKAY);
		axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
		axi_rd(4'h2, 32'h0, RESP_SLVERR);
		axi_wr(4'h2, 32'hFFFF_FFFF, RESP_SLVERR);
		axi_wr(OFF_CTRL, 32'h3, RESP_OKAY);
		axi_rd(OFF_CTRL, 32'h3, RESP_OKAY);
		axi_wr(OFF_BKPT, BK_A | 32'h2, RESP_OKAY);
		for (i = 0; i < 5; i++)
		begin
			issue(~BK_A, (i == 4) ? 4'hF : 4'h8 >> i, i[0]);
			take_chk(exp_idx((i == 4) ? 4'hF : 4'h8 >> i, 1'b0));
			idle();
		end
		issue(BK_A, 4'h4, 1'b0);
		take_chk(C_BKPT);
		idle();
		axi_wr(OFF_BKPT, BK_A, RESP_OKAY);
		issue(BK_A, 4'h0, 1'b0);
		no_take(12);
		axi_wr(OFF_BKPT, BK_A | 32'h2, RESP_OKAY);
		smi_n <= 1'b0;
		take_chk(C_SMI);
		smi_n <= 1'b1;
		idle();
		ext_n <= 1'b0;
		take_chk(C_EXT);
		ext_n <= 1'b1;
		idle();
		axi_wr(OFF_CTRL, 32'h2, RESP_OKAY);
		smi_n <= 1'b0;
		no_take(8);
		smi_n <= 1'b1;
		repeat (4) @(posedge clk);
		axi_wr(OFF_CTRL, 32'h3, RESP_OKAY);
		dec_ev <= 1'b1;
		issue(~BK_A, 4'h8, 1'b0);
		dec_ev <= 1'b0;
		take_chk(C_INSTRUCTION_TRANSLATION_BUFFER);
		take_chk(C_DEC);
		idle();
		issue(~BK_A, 4'h2, 1'b1);
		take_chk(C_STORE);
		mc_req <= 1'b1;
		@(posedge clk);
		mc_req <= 1'b0;
		take_chk(C_MCHECK);
		sr_req <= 1'b1;
		mc_req <= 1'b1;
		@(posedge clk);
		{sr_req, mc_req} <= 2'h0;
		take_chk(C_SRESET);
		take_chk(C_MCHECK);
		idle();
		axi_rd(OFF_LASTVEC, {16'h0000, V_MC}, RESP_OKAY);
		for (i = 0; i < 24; i++)
		begin
			k = $random(seed);
			ra = $random(seed);
			if (k[5:4] == 2'h0)
				ra = BK_A;
			else
				ra[31] = ~BK_A[31];
			issue(ra, k[3:0], k[6]);
			if (exp_idx(k[3:0], ra[31:2] == BK_A[31:2]) >= 0)
				take_chk(exp_idx(k[3:0], ra[31:2] == BK_A[31:2]));
			else
				no_take(12);
			idle();
		end
		axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
		mc_req <= 1'b1;
		@(posedge clk);
		mc_req <= 1'b0;
		no_take(3);
		`CHK("checkstop", 1'b1, checkstop)
		axi_rd(OFF_STATUS, 32'h1, RESP_OKAY);
		test_done();
	end
endmodule
